/* File: bench/flow_meter_control_outputs_test.sv */
/*
 Self-checking bench for the control output block with an output recorder.
 Assumes a short pulse width parameter and the register map of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module flow_meter_control_outputs_test
   import flow_out_pkg::*;
;
   localparam int PW = 4;
   logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [AW-1:0]          paddr;
   logic [31:0]            pwdata, prdata, rd;
   logic signed [31:0]     flow_rate, echo_level;
   logic                   unit_tick, meter_fault;
   logic [NCH-1:0]         ctl_out;
   logic [NCH-1:0][15:0]   rise_cnt, high_len;
   logic [15:0]            base0, base1;
   int                     error_cnt, n_compared;

   flow_meter_control_outputs #(.PULSE_WIDTH(PW)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .flow_rate(flow_rate),
      .echo_level(echo_level), .unit_tick(unit_tick), .meter_fault(meter_fault),
      .ctl_out(ctl_out), .irq(irq));
   out_recorder u_rec (.pclk(pclk), .presetn(presetn), .ctl_out(ctl_out),
      .rise_cnt(rise_cnt), .high_len(high_len));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int i;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (i == 16)
      begin
         error_cnt++;
         tally_and_finish();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic e;
      apb(1'b0, a, 32'h0, rd, e);
      chk(rd, exp);
   endtask : rdc

   function automatic logic [11:0] ch(input int c, input logic [11:0] ofs);
      return 12'(ADDR_CH_BASE + CH_STRIDE * c + ofs);
   endfunction : ch

   function automatic logic [31:0] fn(input out_func_type f0, input out_func_type f1);
      return 32'(f0) | (32'(f1) << FUNC_STRIDE);
   endfunction : fn

   task automatic wait_out(input int c, input logic v);
      int i;
      for (i = 0; i < 64 && ctl_out[c] !== v; i++)
         @(posedge pclk);
      chk(32'(ctl_out[c]), 32'(v));
      if (i == 64)
         tally_and_finish();
   endtask : wait_out

   task automatic hold_chk(input logic [1:0] v);
      repeat (6) @(posedge pclk);
      chk(32'(ctl_out), 32'(v));
   endtask : hold_chk

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      logic e;
      rdc(ADDR_FUNC, 32'h0);
      rdc(ch(0, OFS_DIV), 32'h1);
      wr(ADDR_STATE, 32'h3);
      rdc(ADDR_STATE, 32'h0);
      apb(1'b0, 12'h0FC, 32'h0, rd, e);
      chk(32'(e), 32'h1);
      chk(rd, 32'h0);
      meter_fault <= 1'b1;
      hold_chk(2'b00);
      meter_fault <= 1'b0;
      $display("test regs done");
   endtask : t_regs

   task automatic t_fault();
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_FUNC, fn(FUNC_FAULT, FUNC_NONE));
      @(posedge pclk);
      meter_fault <= 1'b1;
      wait_out(0, 1'b1);
      chk(32'(ctl_out[1]), 32'h0);
      rdc(ADDR_STATE, 32'h1);
      rdc(ADDR_IRQ_STAT, 32'h1);
      chk(32'(irq), 32'h1);
      wr(ADDR_IRQ_STAT, 32'h1);
      @(negedge pclk);
      chk(32'(irq), 32'h0);
      @(posedge pclk);
      meter_fault <= 1'b0;
      wait_out(0, 1'b0);
      $display("test fault done");
   endtask : t_fault

   task automatic t_rate();
      wr(ch(1, OFS_ON), 32'd100);
      wr(ch(1, OFS_OFF), 32'd90);
      flow_rate <= 32'sd50;
      wr(ADDR_FUNC, fn(FUNC_NONE, FUNC_RATE));
      hold_chk(2'b00);
      flow_rate <= 32'sd100;
      wait_out(1, 1'b1);
      flow_rate <= 32'sd95;
      hold_chk(2'b10);
      flow_rate <= 32'sd90;
      wait_out(1, 1'b0);
      $display("test rate done");
   endtask : t_rate

   task automatic t_echo();
      wr(ch(0, OFS_ON), 32'd10);
      wr(ch(0, OFS_OFF), 32'd20);
      echo_level <= 32'sd30;
      wr(ADDR_FUNC, fn(FUNC_ECHO, FUNC_NONE));
      hold_chk(2'b00);
      echo_level <= 32'sd10;
      wait_out(0, 1'b1);
      echo_level <= 32'sd15;
      hold_chk(2'b01);
      echo_level <= 32'sd20;
      wait_out(0, 1'b0);
      $display("test echo done");
   endtask : t_echo

   task automatic ticks(input int n, input int gap);
      repeat (n)
      begin
         @(posedge pclk);
         unit_tick <= 1'b1;
         @(posedge pclk);
         unit_tick <= 1'b0;
         repeat (gap) @(posedge pclk);
      end
      repeat (16 * PW + 20) @(posedge pclk);
   endtask : ticks

   task automatic t_total();
      wr(ch(0, OFS_DIV), 32'd2);
      wr(ch(1, OFS_DIV), 32'd1);
      wr(ADDR_DECADE, 32'h0);
      wr(ADDR_FUNC, fn(FUNC_TOTAL, FUNC_TOTAL));
      base0 = rise_cnt[0];
      base1 = rise_cnt[1];
      ticks(4, 2 * PW);
      chk(32'(rise_cnt[0] - base0), 32'd2);
      chk(32'(rise_cnt[1] - base1), 32'd4);
      chk(32'(high_len[0]), 32'(PW));
      chk(32'(high_len[1]), 32'(PW));
      wr(ch(0, OFS_DIV), 32'd1);
      wr(ADDR_DECADE, 32'h2);
      base0 = rise_cnt[0];
      ticks(200, 0);
      chk(32'(rise_cnt[0] - base0), 32'd2);
      $display("test total done");
   endtask : t_total

   task automatic t_overrun();
      wr(ADDR_DECADE, 32'h7);
      rdc(ADDR_DECADE, 32'h6);
      wr(ADDR_DECADE, 32'h0);
      wr(ADDR_IRQ_STAT, 32'hF);
      rdc(ADDR_IRQ_STAT, 32'h0);
      wr(ADDR_IRQ_MASK, 32'hC);
      ticks(40, 0);
      rdc(ADDR_IRQ_STAT, 32'hF);
      chk(32'(irq), 32'h1);
      $display("test overrun done");
   endtask : t_overrun

   // ****************************************
   // Clock, reset, sequence, watchdog
   // ****************************************
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   initial
   begin
      repeat (100000) @(posedge pclk);
      error_cnt++;
      tally_and_finish();
   end

   initial
   begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; flow_rate = '0; echo_level = '0;
      unit_tick = 1'b0; meter_fault = 1'b0; error_cnt = 0; n_compared = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_fault();
      t_rate();
      t_echo();
      t_total();
      t_overrun();
      tally_and_finish();
   end
endmodule : flow_meter_control_outputs_test
`default_nettype wire

/* File: bench/out_recorder.sv */
/*
 Passive recorder on the far side of the two control outputs.
 Assumes ctl_out is synchronous to pclk; it drives only its rise_cnt and high_len tallies.
*/
`timescale 1ns/1ps
`default_nettype none
module out_recorder
   import flow_out_pkg::*;
(
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // Watched outputs
   input  wire logic [NCH-1:0]        ctl_out,
   // Tallies
   output logic      [NCH-1:0][15:0]  rise_cnt,
   output logic      [NCH-1:0][15:0]  high_len
);
   logic [NCH-1:0]       prev;
   logic [NCH-1:0][15:0] run;

   // ****************************************
   // Edge count and width of last high level
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev     <= '0;
         run      <= '0;
         rise_cnt <= '0;
         high_len <= '0;
      end
      else
      begin
         prev <= ctl_out;
         for (int c = 0; c < NCH; c++)
         begin
            if (ctl_out[c] && !prev[c])
               rise_cnt[c] <= rise_cnt[c] + 16'h0001;
            if (ctl_out[c])
               run[c] <= run[c] + 16'h0001;
            else if (prev[c])
            begin
               high_len[c] <= run[c];
               run[c]      <= '0;
            end
         end
      end
   end
endmodule : out_recorder
`default_nettype wire

/* File: rtl/flow_meter_control_outputs.sv */
/*
 Two switched control outputs of a flow meter with an APB register file,
 sticky interrupt status and mask. Assumes flow_rate, echo_level,
 unit_tick and meter_fault come from measurement logic on pclk.
*/
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - two outputs, each with one selected function
// - rate alarm switches at on and off points
// - totalizer pulse lasts 33 ms per divisor counts
// - decade exponent scales display counts by ten to the power of the exponent
// - exponent zero, divisor two: pulse per two
// - echo alarm on falling, off on rising
// - fault function activates on measurement error
module flow_meter_control_outputs
   import flow_out_pkg::*;
#(
   parameter int DW          = 32,
   parameter int DIV_W       = 16,
   parameter int PULSE_WIDTH = PULSE_CYCLES
)
(
   // APB slave
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [AW-1:0]        paddr,
   input  wire logic [31:0]          pwdata,
   output      logic                 pready,
   output      logic [31:0]          prdata,
   output      logic                 pslverr,
   // Measurement
   input  wire logic signed [DW-1:0] flow_rate,
   input  wire logic signed [DW-1:0] echo_level,
   input  wire logic                 unit_tick,
   input  wire logic                 meter_fault,
   // Outputs
   output      logic [NCH-1:0]       ctl_out,
   output      logic                 irq
);

   if (DW < 2 || DW > 32 || DIV_W < 1 || DIV_W > 32)
   begin : g_bad_width
      $error("unsupported data or divisor width");
   end
   if (PULSE_WIDTH < 1 || PULSE_WIDTH >= (1 << CNT_W))
   begin : g_bad_pulse
      $error("pulse width does not fit the timer");
   end

   // ****************************************
   // Declarations
   // ****************************************
   localparam logic [CNT_W-1:0] PW = CNT_W'(PULSE_WIDTH);

   out_func_type           func_sel [NCH];
   logic signed [DW-1:0]   on_level [NCH];
   logic signed [DW-1:0]   off_level [NCH];
   logic [DIV_W-1:0]       divisor [NCH];
   logic [DECADE_W-1:0]    decade;
   logic [IRQ_W-1:0]       irq_status;
   logic [IRQ_W-1:0]       irq_mask;
   logic [IRQ_W-1:0]       irq_event;
   logic [PRE_W-1:0]       pre_count;
   logic [PRE_W-1:0]       pre_limit;
   logic                   display_tick;
   logic [NCH-1:0]         alarm_active;
   logic [NCH-1:0]         tot_pulse;
   logic [NCH-1:0]         next_ctl;
   logic [NCH-1:0]         ctl_prev;
   logic                   wr;
   logic                   setup;
   logic                   mapped;
   logic [31:0]            next_rdata;

   // ****************************************
   // Decade prescaler
   // ****************************************
   function automatic logic [PRE_W-1:0] pow10(input logic [DECADE_W-1:0] e);
      logic [PRE_W-1:0] r;
      r = PRE_W'(1);
      for (int k = 0; k < DECADE_MAX; k++)
         if (k < int'(e))
            r = PRE_W'(r * PRE_W'(10));
      return r;
   endfunction : pow10

   assign pre_limit = pow10(decade);
   assign display_tick = unit_tick && (pre_count >= pre_limit - PRE_W'(1));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_count <= '0;
      else if (display_tick)
         pre_count <= '0;
      else if (unit_tick)
         pre_count <= pre_count + PRE_W'(1);
   end

   // ****************************************
   // APB access
   // ****************************************
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign pready = psel && penable;
   assign pslverr = pready && !mapped;

   function automatic logic hit_ch(input logic [AW-1:0] a, input int ch,
                                   input logic [11:0] ofs);
      return a == AW'(ADDR_CH_BASE + CH_STRIDE * 12'(ch) + ofs);
   endfunction : hit_ch

   always_comb
   begin
      mapped = (paddr == ADDR_FUNC) || (paddr == ADDR_STATE)
               || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK)
               || (paddr == ADDR_DECADE);
      next_rdata = '0;
      case (paddr)
         ADDR_STATE:
            next_rdata[NCH-1:0] = ctl_out;
         ADDR_IRQ_STAT:
            next_rdata[IRQ_W-1:0] = irq_status;
         ADDR_IRQ_MASK:
            next_rdata[IRQ_W-1:0] = irq_mask;
         ADDR_DECADE:
            next_rdata[DECADE_W-1:0] = decade;
         default:
            next_rdata = '0;
      endcase
      for (int c = 0; c < NCH; c++)
      begin
         if (paddr == ADDR_FUNC)
            next_rdata[c*FUNC_STRIDE +: FUNC_W] = func_sel[c];
         if (hit_ch(paddr, c, OFS_ON))
            next_rdata = 32'(on_level[c]);
         if (hit_ch(paddr, c, OFS_OFF))
            next_rdata = 32'(off_level[c]);
         if (hit_ch(paddr, c, OFS_DIV))
            next_rdata = 32'(divisor[c]);
         mapped = mapped || hit_ch(paddr, c, OFS_ON) || hit_ch(paddr, c, OFS_OFF)
                  || hit_ch(paddr, c, OFS_DIV);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (setup && !pwrite)
         prdata <= next_rdata;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         decade <= '0;
         irq_mask <= '0;
      end
      else if (wr && paddr == ADDR_DECADE)
         decade <= (pwdata[DECADE_W-1:0] > DECADE_W'(DECADE_MAX)) ?
                   DECADE_W'(DECADE_MAX) : pwdata[DECADE_W-1:0];
      else if (wr && paddr == ADDR_IRQ_MASK)
         irq_mask <= pwdata[IRQ_W-1:0];
   end

   // ****************************************
   // Channels
   // ****************************************
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      logic                 is_alarm;
      logic                 is_echo;
      logic signed [DW-1:0] watched;

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            func_sel[i] <= FUNC_NONE;
            on_level[i] <= '0;
            off_level[i] <= '0;
            divisor[i] <= DIV_W'(1);
         end
         else if (wr)
         begin
            if (paddr == ADDR_FUNC)
               func_sel[i] <= out_func_type'(pwdata[i*FUNC_STRIDE +: FUNC_W]);
            if (hit_ch(paddr, i, OFS_ON))
               on_level[i] <= pwdata[DW-1:0];
            if (hit_ch(paddr, i, OFS_OFF))
               off_level[i] <= pwdata[DW-1:0];
            if (hit_ch(paddr, i, OFS_DIV))
               divisor[i] <= pwdata[DIV_W-1:0];
         end
      end

      assign is_echo = (func_sel[i] == FUNC_ECHO);
      assign is_alarm = (func_sel[i] == FUNC_RATE) || is_echo;
      assign watched = is_echo ? echo_level : flow_rate;

      hysteresis_alarm #(.W(DW)) u_alarm
      (
         .pclk      (pclk),
         .presetn   (presetn),
         .enable    (is_alarm),
         .low_alarm (is_echo),
         .value     (watched),
         .on_level  (on_level[i]),
         .off_level (off_level[i]),
         .active    (alarm_active[i])
      );

      pulse_train #(.DIV_W(DIV_W)) u_pulse
      (
         .pclk         (pclk),
         .presetn      (presetn),
         .enable       (func_sel[i] == FUNC_TOTAL),
         .count_tick   (display_tick),
         .divisor      (divisor[i]),
         .pulse_cycles (PW),
         .pulse        (tot_pulse[i]),
         .overrun      (irq_event[IRQ_OVR_LSB + i])
      );

      always_comb
      begin
         case (func_sel[i])
            FUNC_RATE, FUNC_ECHO:
               next_ctl[i] = alarm_active[i];
            FUNC_TOTAL:
               next_ctl[i] = tot_pulse[i];
            FUNC_FAULT:
               next_ctl[i] = meter_fault;
            default:
               next_ctl[i] = 1'b0;
         endcase
      end

      assign irq_event[i] = ctl_out[i] && !ctl_prev[i];
   end

   // ****************************************
   // Outputs and interrupts
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_out <= '0;
         ctl_prev <= '0;
      end
      else
      begin
         ctl_out <= next_ctl;
         ctl_prev <= ctl_out;
      end
   end

   // Hardware set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= '0;
      else if (wr && paddr == ADDR_IRQ_STAT)
         irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_event;
      else
         irq_status <= irq_status | irq_event;
   end

   assign irq = |(irq_status & irq_mask);

   // ****************************************
   // Checks
   // ****************************************
   a_fault_follows : assert property (@(posedge pclk) disable iff (!presetn)
      func_sel[0] == FUNC_FAULT && meter_fault |=> ctl_out[0])
      else $error("fault output not active");

   a_none_idle : assert property (@(posedge pclk) disable iff (!presetn)
      func_sel[1] == FUNC_NONE |=> !ctl_out[1])
      else $error("unused output active");

   a_decade_unit : assert property (@(posedge pclk) disable iff (!presetn)
      decade == '0 && unit_tick |-> display_tick)
      else $error("exponent zero missed a count");

   a_status_sticky : assert property (@(posedge pclk) disable iff (!presetn)
      irq_status[0] && !(wr && paddr == ADDR_IRQ_STAT) |=> irq_status[0])
      else $error("status bit lost");

   a_rise_flags : assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ctl_out[0]) |=> irq_status[0])
      else $error("activation not flagged");

endmodule : flow_meter_control_outputs
`default_nettype wire

/* File: rtl/flow_out_pkg.sv */
/*
 Constants, register map and types shared by the control output block.
 Assumes a 125 MHz pclk and a 12-bit APB byte address.
*/
package flow_out_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_KHZ      = 125000;
   localparam int PULSE_MS     = 33;
   localparam int PULSE_CYCLES = PULSE_MS * CLK_KHZ;
   localparam int CNT_W        = 23;

   // ****************************************
   // Register map
   // ****************************************
   localparam int          AW            = 12;
   localparam int          NCH           = 2;
   localparam logic [11:0] ADDR_FUNC     = 12'h000;
   localparam logic [11:0] ADDR_STATE    = 12'h004;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
   localparam logic [11:0] ADDR_DECADE   = 12'h010;
   localparam logic [11:0] ADDR_CH_BASE  = 12'h020;
   localparam logic [11:0] CH_STRIDE     = 12'h010;
   localparam logic [11:0] OFS_ON        = 12'h000;
   localparam logic [11:0] OFS_OFF       = 12'h004;
   localparam logic [11:0] OFS_DIV       = 12'h008;

   // ****************************************
   // Fields
   // ****************************************
   localparam int FUNC_W      = 3;
   localparam int FUNC_STRIDE = 4;
   localparam int DECADE_W    = 3;
   localparam int DECADE_MAX  = 6;
   localparam int PRE_W       = 20;
   localparam int IRQ_W       = 4;
   localparam int IRQ_OVR_LSB = 2;
   localparam int OWE_W       = 4;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0]
   {
      FUNC_NONE  = 3'h0,
      FUNC_RATE  = 3'h1,
      FUNC_ECHO  = 3'h2,
      FUNC_TOTAL = 3'h3,
      FUNC_FAULT = 3'h4
   } out_func_type;

   typedef enum logic [2:0]
   {
      P_IDLE = 3'b001,
      P_HIGH = 3'b010,
      P_GAP  = 3'b100
   } pulse_state_type;

endpackage : flow_out_pkg

/* File: rtl/hysteresis_alarm.sv */
/*
 Two-threshold alarm with deadband for one output channel.
 Assumes thresholds and value are stable synchronous words on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module hysteresis_alarm
   import flow_out_pkg::*;
#(
   parameter int W = 32
)
(
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // Control
   input  wire logic                enable,
   input  wire logic                low_alarm,
   input  wire logic signed [W-1:0] value,
   input  wire logic signed [W-1:0] on_level,
   input  wire logic signed [W-1:0] off_level,
   // Result
   output      logic                active
);

   logic low_mode;

   // On point below off point means alarm on a falling value
   assign low_mode = low_alarm || (on_level < off_level);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         active <= 1'b0;
      else if (!enable)
         active <= 1'b0;
      else if (low_mode)
      begin
         if (value <= on_level)
            active <= 1'b1;
         else if (value >= off_level)
            active <= 1'b0;
      end
      else
      begin
         if (value >= on_level)
            active <= 1'b1;
         else if (value <= off_level)
            active <= 1'b0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_high_sets : assert property (@(posedge pclk) disable iff (!presetn)
      enable && !low_mode && value >= on_level |=> active)
      else $error("high alarm did not set");

   a_low_sets : assert property (@(posedge pclk) disable iff (!presetn)
      enable && low_mode && value <= on_level |=> active)
      else $error("low alarm did not set");

   a_band_holds : assert property (@(posedge pclk) disable iff (!presetn)
      enable && $past(enable) && value > on_level && value < off_level && low_mode
      |=> active == $past(active))
      else $error("alarm changed inside deadband");

endmodule : hysteresis_alarm
`default_nettype wire

/* File: rtl/pulse_train.sv */
/*
 Divides display advances by a divisor and emits fixed-width pulses.
 Owed pulses queue in a small saturating counter; a gap of equal width follows.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_train
   import flow_out_pkg::*;
#(
   parameter int DIV_W = 16
)
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Control
   input  wire logic             enable,
   input  wire logic             count_tick,
   input  wire logic [DIV_W-1:0] divisor,
   input  wire logic [CNT_W-1:0] pulse_cycles,
   // Result
   output      logic             pulse,
   output      logic             overrun
);

   pulse_state_type  state;
   logic [DIV_W-1:0] div_count;
   logic [OWE_W-1:0] owe;
   logic [CNT_W-1:0] timer;
   logic             inc;
   logic             take;
   logic             tmr_done;

   // Zero divisor is not valid and yields no pulses
   assign inc = enable && count_tick && (divisor != '0)
                && (div_count >= divisor - DIV_W'(1));
   assign take = (state == P_IDLE) && (owe != '0) && enable;
   assign tmr_done = (timer >= pulse_cycles - CNT_W'(1));
   assign pulse = (state == P_HIGH);
   assign overrun = inc && !take && (owe == '1);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_count <= '0;
      else if (!enable || inc)
         div_count <= '0;
      else if (count_tick && divisor != '0)
         div_count <= div_count + DIV_W'(1);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         owe <= '0;
      else if (!enable)
         owe <= '0;
      else if (inc && !take && owe != '1)
         owe <= owe + OWE_W'(1);
      else if (take && !inc)
         owe <= owe - OWE_W'(1);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= P_IDLE;
         timer <= '0;
      end
      else
      begin
         case (state)
            P_IDLE:
               if (take)
               begin
                  state <= P_HIGH;
                  timer <= '0;
               end
            P_HIGH:
               if (tmr_done)
               begin
                  state <= P_GAP;
                  timer <= '0;
               end
               else
                  timer <= timer + CNT_W'(1);
            P_GAP:
               if (tmr_done)
                  state <= P_IDLE;
               else
                  timer <= timer + CNT_W'(1);
            default:
               state <= P_IDLE;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_pulse_width : assert property (@(posedge pclk) disable iff (!presetn)
      $fell(pulse) |-> $past(timer) == pulse_cycles - CNT_W'(1))
      else $error("pulse width wrong");

   a_owe_counts : assert property (@(posedge pclk) disable iff (!presetn)
      inc && !take && owe != '1 |=> owe == $past(owe) + OWE_W'(1))
      else $error("owed pulse lost");

endmodule : pulse_train
`default_nettype wire
